// File: rtl/iwd_decoder.v
`timescale 1ns/10ps
`default_nettype none
`include "iwd_consts.vh"

module iwd_decoder #(
    parameter [6:0] PORT_LO = 7'h05,
    parameter [6:0] PORT_HI = 7'h07,
    parameter [6:0] TIMER_ADDR = 7'h01
) (
    input wire clock,
    input wire resetn,
    input wire [13:0] instr_word,
    input wire [7:0] file_rdata,
    input wire [7:0] pin_rdata,
    input wire prescaler_to_timer,
    output reg [6:0] file_addr_q,
    output reg [7:0] file_wdata_q,
    output reg file_we_q,
    output reg [7:0] acc_q,
    output reg [4:0] status_q,
    output reg [10:0] pc_load_q,
    output reg pc_load_en_q,
    output reg push_q,
    output reg pop_q,
    output reg fetch_q,
    output reg flush_q,
    output reg prescaler_clr_q,
    output reg watchdog_clr_q,
    output reg standby_q
);
    // ----------------------------------------
    // Sequencer states
    // ----------------------------------------
    localparam [1:0] ST_EXEC = 2'b01;
    localparam [1:0] ST_NOP = 2'b10;

    reg [1:0] state_q;
    reg [1:0] state_d;
    wire cycle_end;

    // Instruction cycle strobe from the oscillator divider
    iwd_phase_gen #(
        .PERIODS(`IWD_OSC_PER_CYCLE)
    ) u_phase (
        .clock(clock),
        .resetn(resetn),
        .cycle_end(cycle_end)
    );

    // ----------------------------------------
    // Field split
    // ----------------------------------------
    wire [1:0] cls = instr_word[`IWD_CLS_HI:`IWD_CLS_LO];
    wire [3:0] sub = instr_word[`IWD_SUB_HI:`IWD_SUB_LO];
    wire dest_file = instr_word[`IWD_D_BIT];
    wire [6:0] faddr = instr_word[6:0];
    wire [2:0] bsel = instr_word[9:`IWD_BIT_LO];
    wire [7:0] lit = instr_word[7:0];
    wire [10:0] target = instr_word[10:0];

    // Ports read back the pins, not the latch
    wire is_port = (faddr >= PORT_LO) && (faddr <= PORT_HI);
    wire [7:0] fval = is_port ? pin_rdata : file_rdata;

    // ----------------------------------------
    // Shared adder
    // ----------------------------------------
    reg [7:0] alu_a;
    reg [7:0] alu_b;
    reg alu_sub;
    wire [7:0] alu_res;
    wire alu_c;
    wire alu_dc;

    iwd_alu u_alu (
        .a(alu_a),
        .b(alu_b),
        .sub(alu_sub),
        .res(alu_res),
        .carry(alu_c),
        .nibble_carry(alu_dc)
    );

    // ----------------------------------------
    // Decode of the current word
    // ----------------------------------------
    reg [7:0] res;
    reg wr_file;
    reg wr_acc;
    reg upd_z;
    reg upd_c;
    reg upd_dc;
    reg new_c;
    reg skip;
    reg branch;
    reg do_push;
    reg do_pop;
    reg kick;
    reg sleep_op;
    reg [7:0] bmask;

    // One combinational decode; don't-care bits never enter a compare
    always @* begin
        alu_a = fval;
        alu_b = acc_q;
        alu_sub = 1'b0;
        res = 8'h00;
        wr_file = 1'b0;
        wr_acc = 1'b0;
        upd_z = 1'b0;
        upd_c = 1'b0;
        upd_dc = 1'b0;
        new_c = status_q[`IWD_ST_C];
        skip = 1'b0;
        branch = 1'b0;
        do_push = 1'b0;
        do_pop = 1'b0;
        kick = 1'b0;
        sleep_op = 1'b0;
        bmask = 8'h01 << bsel;
        case (cls)
            `IWD_CLS_BYTE: begin
                wr_file = dest_file;
                wr_acc = ~dest_file;
                upd_z = 1'b1;
                case (sub)
                    `IWD_OP_MISC: begin
                        upd_z = 1'b0;
                        wr_acc = 1'b0;
                        res = acc_q;
                        if (dest_file) begin
                            wr_file = 1'b1; // store_acc
                        end else if (lit == `IWD_LW_RETURN ||
                                     lit == `IWD_LW_RETINT) begin
                            do_pop = 1'b1;
                            branch = 1'b1;
                        end else if (lit == `IWD_LW_KICK) begin
                            kick = 1'b1;
                        end else if (lit == `IWD_LW_SLEEP) begin
                            sleep_op = 1'b1;
                        end
                    end
                    `IWD_OP_CLR: res = 8'h00; // zero_file_reg or zero_acc
                    `IWD_OP_SUB: begin
                        alu_sub = 1'b1;
                        res = alu_res;
                        upd_c = 1'b1;
                        upd_dc = 1'b1;
                        new_c = alu_c;
                    end
                    `IWD_OP_DEC: res = fval - 8'h01;
                    `IWD_OP_OR: res = fval | acc_q;
                    `IWD_OP_AND: res = fval & acc_q;
                    `IWD_OP_XOR: res = fval ^ acc_q;
                    `IWD_OP_ADD: begin
                        res = alu_res;
                        upd_c = 1'b1;
                        upd_dc = 1'b1;
                        new_c = alu_c;
                    end
                    `IWD_OP_MOV: res = fval;
                    `IWD_OP_COM: res = ~fval;
                    `IWD_OP_INC: res = fval + 8'h01;
                    `IWD_OP_DECSZ: begin
                        res = fval - 8'h01;
                        upd_z = 1'b0;
                        skip = (res == 8'h00);
                    end
                    `IWD_OP_INCSZ: begin
                        res = fval + 8'h01;
                        upd_z = 1'b0;
                        skip = (res == 8'h00);
                    end
                    `IWD_OP_ROR: begin
                        res = {status_q[`IWD_ST_C], fval[7:1]};
                        upd_z = 1'b0;
                        upd_c = 1'b1;
                        new_c = fval[0];
                    end
                    `IWD_OP_ROL: begin
                        res = {fval[6:0], status_q[`IWD_ST_C]};
                        upd_z = 1'b0;
                        upd_c = 1'b1;
                        new_c = fval[7];
                    end
                    default: begin
                        res = {fval[3:0], fval[7:4]}; // nibble_exchange
                        upd_z = 1'b0;
                    end
                endcase
            end
            `IWD_CLS_BIT: begin
                case (sub[3:2])
                    2'b00: begin
                        res = fval & ~bmask;
                        wr_file = 1'b1;
                    end
                    2'b01: begin
                        res = fval | bmask;
                        wr_file = 1'b1;
                    end
                    2'b10: skip = ((fval & bmask) == 8'h00);
                    default: skip = ((fval & bmask) != 8'h00);
                endcase
            end
            `IWD_CLS_JUMP: begin
                branch = 1'b1;
                do_push = ~instr_word[11];
            end
            default: begin
                alu_a = lit;
                wr_acc = 1'b1;
                if (sub[3:1] == 3'b110 || sub[3:1] == 3'b111) begin
                    alu_sub = ~sub[1];
                    res = alu_res;
                    upd_z = 1'b1;
                    upd_c = 1'b1;
                    upd_dc = 1'b1;
                    new_c = alu_c;
                end else if (sub == `IWD_LOP_OR) begin
                    res = lit | acc_q;
                    upd_z = 1'b1;
                end else if (sub == `IWD_LOP_AND) begin
                    res = lit & acc_q;
                    upd_z = 1'b1;
                end else if (sub == `IWD_LOP_XOR) begin
                    res = lit ^ acc_q;
                    upd_z = 1'b1;
                end else begin
                    res = lit;
                    if (sub[3:2] == 2'b01) begin
                        do_pop = 1'b1;
                        branch = 1'b1;
                    end
                end
            end
        endcase
    end

    // Taken skip or branch forces one no-op cycle
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_EXEC: begin
                if (cycle_end && (skip || branch)) begin
                    state_d = ST_NOP;
                end
            end
            ST_NOP: begin
                if (cycle_end) begin
                    state_d = ST_EXEC;
                end
            end
            default: state_d = ST_EXEC;
        endcase
    end

    // ----------------------------------------
    // Commit at end of each instruction cycle except the forced no-op cycle
    // ----------------------------------------
    wire commit = cycle_end && (state_q == ST_EXEC);

    // Strobes last one oscillator period; acc and status written only on commit
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_EXEC;
            file_addr_q <= 7'h00;
            file_wdata_q <= 8'h00;
            file_we_q <= 1'b0;
            acc_q <= `IWD_ACC_RST;
            status_q <= `IWD_STATUS_RST;
            pc_load_q <= 11'h000;
            pc_load_en_q <= 1'b0;
            push_q <= 1'b0;
            pop_q <= 1'b0;
            fetch_q <= 1'b0;
            flush_q <= 1'b0;
            prescaler_clr_q <= 1'b0;
            watchdog_clr_q <= 1'b0;
            standby_q <= 1'b0;
        end else begin
            state_q <= state_d;
            file_addr_q <= faddr;
            file_we_q <= commit && wr_file;
            file_wdata_q <= res;
            pc_load_en_q <= commit && (cls == `IWD_CLS_JUMP);
            pc_load_q <= target;
            push_q <= commit && do_push;
            pop_q <= commit && do_pop;
            fetch_q <= cycle_end;
            flush_q <= commit && (skip || branch);
            prescaler_clr_q <= commit && wr_file && (faddr == TIMER_ADDR)
                               && prescaler_to_timer;
            watchdog_clr_q <= commit && (kick || sleep_op);
            standby_q <= commit && sleep_op;
            if (commit) begin
                if (wr_acc) begin
                    acc_q <= res;
                end
                if (upd_z) begin
                    status_q[`IWD_ST_Z] <= (res == 8'h00);
                end
                if (upd_c) begin
                    status_q[`IWD_ST_C] <= new_c;
                end
                if (upd_dc) begin
                    status_q[`IWD_ST_NIBBLE] <= alu_dc;
                end
                if (kick || sleep_op) begin
                    status_q[`IWD_ST_EXPIRY] <= 1'b1;
                    status_q[`IWD_ST_SLEEP] <= ~sleep_op;
                end
            end
        end
    end
endmodule

`default_nettype wire

// File: rtl/iwd_consts.vh
`ifndef IWD_CONSTS_VH
`define IWD_CONSTS_VH

// ----------------------------------------
// Instruction word layout
// ----------------------------------------
`define IWD_WORD_W 14
`define IWD_FILE_W 7
`define IWD_PC_W 11
`define IWD_D_BIT 7
`define IWD_BIT_LO 7
`define IWD_CLS_HI 13
`define IWD_CLS_LO 12
`define IWD_SUB_HI 11
`define IWD_SUB_LO 8

// ----------------------------------------
// Class and operation codes
// ----------------------------------------
`define IWD_CLS_BYTE 2'h0
`define IWD_CLS_BIT 2'h1
`define IWD_CLS_JUMP 2'h2
`define IWD_CLS_LIT 2'h3
`define IWD_OP_MISC 4'h0
`define IWD_OP_CLR 4'h1
`define IWD_OP_SUB 4'h2
`define IWD_OP_DEC 4'h3
`define IWD_OP_OR 4'h4
`define IWD_OP_AND 4'h5
`define IWD_OP_XOR 4'h6
`define IWD_OP_ADD 4'h7
`define IWD_OP_MOV 4'h8
`define IWD_OP_COM 4'h9
`define IWD_OP_INC 4'hA
`define IWD_OP_DECSZ 4'hB
`define IWD_OP_ROR 4'hC
`define IWD_OP_ROL 4'hD
`define IWD_OP_SWAP 4'hE
`define IWD_OP_INCSZ 4'hF
`define IWD_LOP_OR 4'h8
`define IWD_LOP_AND 4'h9
`define IWD_LOP_XOR 4'hA
`define IWD_LW_RETURN 8'h08
`define IWD_LW_RETINT 8'h09
`define IWD_LW_SLEEP 8'h63
`define IWD_LW_KICK 8'h64

// ----------------------------------------
// Status bit positions, reset values, file address limit and cycle length
// ----------------------------------------
`define IWD_ST_C 0
`define IWD_ST_NIBBLE 1
`define IWD_ST_Z 2
`define IWD_ST_SLEEP 3
`define IWD_ST_EXPIRY 4
`define IWD_ACC_RST 8'h00
`define IWD_STATUS_RST 5'h18
`define IWD_FILE_ADDR_MAX 7'h7F
`define IWD_OSC_PER_CYCLE 4

`endif

// File: rtl/iwd_phase_gen.v
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Divides the oscillator into instruction cycles
// ----------------------------------------
module iwd_phase_gen #(
    parameter PERIODS = 4
) (
    input wire clock,
    input wire resetn,
    output reg cycle_end
);
    reg [2:0] cnt_q;

    // Last of the oscillator periods ends the cycle
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 3'h0;
            cycle_end <= 1'b0;
        end else begin
            if (cnt_q == PERIODS - 1) begin
                cnt_q <= 3'h0;
            end else begin
                cnt_q <= cnt_q + 3'h1;
            end
            cycle_end <= (cnt_q == PERIODS - 2);
        end
    end
endmodule

`default_nettype wire

// File: rtl/iwd_alu.v
`timescale 1ns/10ps
`default_nettype none
`include "iwd_consts.vh"

// ----------------------------------------
// Byte arithmetic with carry and nibble carry
// ----------------------------------------
module iwd_alu (
    input wire [7:0] a,
    input wire [7:0] b,
    input wire sub,
    output wire [7:0] res,
    output wire carry,
    output wire nibble_carry
);
    wire [7:0] bx;
    wire [8:0] full;
    wire [4:0] low;

    // Subtract as a + ~b + 1, so carry means no borrow
    assign bx = sub ? ~b : b;
    assign full = {1'b0, a} + {1'b0, bx} + {8'h00, sub};
    assign low = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, sub};
    assign res = full[7:0];
    assign carry = full[8];
    assign nibble_carry = low[4];
endmodule

`default_nettype wire

// File: sim/iwd_properties.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Port checks beside the instruction decoder
// ----------------------------------------
module iwd_properties #(
    parameter [6:0] TIMER_ADDR = 7'h01
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [13:0] instr_word,
    input wire logic prescaler_to_timer,
    input wire logic [6:0] file_addr_q,
    input wire logic file_we_q,
    input wire logic [4:0] status_q,
    input wire logic [10:0] pc_load_q,
    input wire logic pc_load_en_q,
    input wire logic push_q,
    input wire logic pop_q,
    input wire logic fetch_q,
    input wire logic flush_q,
    input wire logic prescaler_clr_q,
    input wire logic watchdog_clr_q,
    input wire logic standby_q
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    // Cycle spacing, decode fields and side effects
    property p_cycle; fetch_q |=> !fetch_q [*3] ##1 fetch_q; endproperty
    property p_addr; 1'b1 |=> file_addr_q == $past(instr_word[6:0]); endproperty
    property p_target;
        pc_load_en_q |-> pc_load_q == $past(instr_word[10:0]) && $past(instr_word[13:12]) == 2'h2;
    endproperty
    property p_flush; (pc_load_en_q || push_q) |-> flush_q; endproperty
    property p_ret; pop_q |-> flush_q && $stable(status_q); endproperty
    property p_kick; watchdog_clr_q |-> status_q[4] && $past(instr_word[13:8]) == 6'h00; endproperty
    property p_standby;
        standby_q |-> status_q[4:3] == 2'b10 && $past(instr_word[7:0]) == 8'h63;
    endproperty
    property p_prescale;
        prescaler_clr_q |-> file_we_q && file_addr_q == TIMER_ADDR && $past(prescaler_to_timer);
    endproperty
    property p_dest;
        file_we_q && $past(instr_word[13:12]) == 2'h0 |-> $past(instr_word[7]);
    endproperty

    a_cycle: assert property (p_cycle) else $error("instruction cycle not four clocks");
    a_addr: assert property (p_addr) else $error("file address not low seven bits");
    a_target: assert property (p_target) else $error("branch target wrong");
    a_flush: assert property (p_flush) else $error("branch without no-op cycle");
    a_ret: assert property (p_ret) else $error("return changed flags or no flush");
    a_kick: assert property (p_kick) else $error("watchdog clear wrong");
    a_standby: assert property (p_standby) else $error("standby flags wrong");
    a_prescale: assert property (p_prescale) else $error("prescaler clear wrong");
    a_dest: assert property (p_dest) else $error("file write with destination 0");

    // Main scenarios reached
    c_call: cover property (push_q);
    c_skip: cover property (flush_q && !pc_load_en_q && !pop_q);
    c_prescale: cover property (prescaler_clr_q);
endmodule

bind iwd_decoder iwd_properties #(.TIMER_ADDR(TIMER_ADDR)) u_props (
    .clock(clock), .resetn(resetn), .instr_word(instr_word),
    .prescaler_to_timer(prescaler_to_timer), .file_addr_q(file_addr_q), .file_we_q(file_we_q),
    .status_q(status_q), .pc_load_q(pc_load_q), .pc_load_en_q(pc_load_en_q), .push_q(push_q),
    .pop_q(pop_q), .fetch_q(fetch_q), .flush_q(flush_q), .prescaler_clr_q(prescaler_clr_q),
    .watchdog_clr_q(watchdog_clr_q), .standby_q(standby_q)
);

`default_nettype wire

// File: sim/iwd_far_model.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// File registers and port pins beside the decoder
// ----------------------------------------
module iwd_far_model #(
    parameter [7:0] PIN_LEVELS = 8'hC3
) (
    input wire logic clock,
    input wire logic [6:0] file_addr_q,
    input wire logic [7:0] file_wdata_q,
    input wire logic file_we_q,
    output logic [7:0] file_rdata,
    output logic [7:0] pin_rdata
);
    logic [7:0] mem_q [0:127];

    // Pins differ from the latch written before the second port read, so a latch read would be caught
    assign pin_rdata = PIN_LEVELS;
    assign file_rdata = mem_q[file_addr_q];

    // Write back only on the strobe
    always @(posedge clock) begin
        if (file_we_q === 1'b1) begin
            mem_q[file_addr_q] <= file_wdata_q;
        end
    end
endmodule

`default_nettype wire

// File: sim/test_instruction_word_decoder.sv
`timescale 1ns/10ps
`default_nettype none

module test_instruction_word_decoder;
    localparam logic [7:0] k_we = 8'h80, k_fl = 8'h40, k_pu = 8'h20, k_po = 8'h10;
    localparam logic [7:0] k_pc = 8'h08, k_pr = 8'h04, k_wd = 8'h02, k_sb = 8'h01;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [13:0] instr_word = 14'h0000;
    logic prescaler_to_timer = 1'b0;
    logic [6:0] file_addr_q;
    logic [7:0] file_wdata_q, acc_q, file_rdata, pin_rdata;
    logic [4:0] status_q, st;
    logic [10:0] pc_load_q;
    logic file_we_q, pc_load_en_q, push_q, pop_q, fetch_q, flush_q;
    logic prescaler_clr_q, watchdog_clr_q, standby_q;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;

    iwd_decoder uut (
        .clock(clock), .resetn(resetn), .instr_word(instr_word), .file_rdata(file_rdata),
        .pin_rdata(pin_rdata), .prescaler_to_timer(prescaler_to_timer),
        .file_addr_q(file_addr_q), .file_wdata_q(file_wdata_q), .file_we_q(file_we_q),
        .acc_q(acc_q), .status_q(status_q), .pc_load_q(pc_load_q), .pc_load_en_q(pc_load_en_q),
        .push_q(push_q), .pop_q(pop_q), .fetch_q(fetch_q), .flush_q(flush_q),
        .prescaler_clr_q(prescaler_clr_q), .watchdog_clr_q(watchdog_clr_q), .standby_q(standby_q)
    );
    iwd_far_model u_far (
        .clock(clock), .file_addr_q(file_addr_q), .file_wdata_q(file_wdata_q),
        .file_we_q(file_we_q), .file_rdata(file_rdata), .pin_rdata(pin_rdata)
    );

    // ----------------------------------------
    // Clock, run limit and reporting
    // ----------------------------------------
    always #50 clock = ~clock;

    // About 60 instructions of four clocks; far below this ceiling
    always @(posedge clock) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            close_out();
        end
    end

    task automatic close_out;
        $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // ----------------------------------------
    // One word per instruction cycle, judged when its pulses stand
    // ----------------------------------------
    task automatic ex(input logic [13:0] w, input logic [7:0] ep, input logic [7:0] ea,
                      input logic [4:0] es, input logic [7:0] ed);
        int n;
        n = 0;
        instr_word <= w;
        do begin
            @(posedge clock);
            n++;
        end while (fetch_q !== 1'b1 && n < 12);
        chk({file_we_q, flush_q, push_q, pop_q, pc_load_en_q, prescaler_clr_q,
             watchdog_clr_q, standby_q}, ep);
        chk(acc_q, ea);
        chk(status_q, es);
        if (ep[7]) chk(file_wdata_q, ed);
        if (ep[3]) chk(pc_load_q, w[10:0]);
        st = es;
    endtask

    // Branch or skip, then a word that must be dropped
    task automatic br(input logic [13:0] w, input logic [7:0] ep, input logic [7:0] ea,
                      input logic [7:0] ed);
        ex(w, ep, ea, st, ed);
        ex(14'h3077, 8'h00, ea, st, 8'h00);
    endtask

    task automatic set_file(input logic [6:0] f, input logic [7:0] v);
        ex({2'h3, 4'h0, v}, 8'h00, v, st, 8'h00);
        ex({2'h0, 4'h0, 1'b1, f}, k_we, v, st, v);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_literal;
        ex({2'h3, 4'h0, 8'h5A}, 8'h00, 8'h5A, 5'h18, 8'h00);
        ex({2'h3, 4'h3, 8'h0F}, 8'h00, 8'h0F, 5'h18, 8'h00);
        ex({2'h3, 4'hE, 8'hF1}, 8'h00, 8'h00, 5'h1F, 8'h00);
        ex({2'h3, 4'hC, 8'h05}, 8'h00, 8'h05, 5'h1B, 8'h00);
        ex({2'h3, 4'h8, 8'hA0}, 8'h00, 8'hA5, 5'h1B, 8'h00);
        ex({2'h3, 4'h9, 8'h0F}, 8'h00, 8'h05, 5'h1B, 8'h00);
        ex({2'h3, 4'hD, 8'h03}, 8'h00, 8'hFE, 5'h18, 8'h00);
        ex({2'h3, 4'hA, 8'hFE}, 8'h00, 8'h00, 5'h1C, 8'h00);
    endtask

    task automatic t_byte;
        set_file(7'h20, 8'h81);
        ex({2'h0, 4'hD, 1'b0, 7'h20}, 8'h00, 8'h02, 5'h1D, 8'h00);
        ex({2'h0, 4'hC, 1'b1, 7'h20}, k_we, 8'h02, 5'h1D, 8'hC0);
        ex({2'h0, 4'h4, 1'b1, 7'h20}, k_we, 8'h02, 5'h19, 8'hC2);
        ex({2'h0, 4'h6, 1'b0, 7'h20}, 8'h00, 8'hC0, 5'h19, 8'h00);
        ex({2'h0, 4'h2, 1'b0, 7'h20}, 8'h00, 8'h02, 5'h1B, 8'h00);
        ex({2'h0, 4'h7, 1'b0, 7'h20}, 8'h00, 8'hC4, 5'h18, 8'h00);
        ex({2'h0, 4'h1, 1'b1, 7'h20}, k_we, 8'hC4, 5'h1C, 8'h00);
        ex(14'h0103, 8'h00, 8'h00, 5'h1C, 8'h00);
        ex({2'h0, 4'h9, 1'b1, 7'h20}, k_we, 8'h00, 5'h18, 8'hFF);
        ex({2'h0, 4'hA, 1'b1, 7'h20}, k_we, 8'h00, 5'h1C, 8'h00);
        ex({2'h0, 4'h3, 1'b0, 7'h20}, 8'h00, 8'hFF, 5'h18, 8'h00);
        ex({2'h0, 4'h5, 1'b1, 7'h20}, k_we, 8'hFF, 5'h1C, 8'h00);
        ex({2'h0, 4'hE, 1'b0, 7'h05}, 8'h00, 8'h3C, 5'h1C, 8'h00);
    endtask

    task automatic t_skip;
        set_file(7'h22, 8'h01);
        ex({2'h3, 4'h8, 8'h01}, 8'h00, 8'h01, 5'h18, 8'h00);
        br({2'h0, 4'hB, 1'b1, 7'h22}, k_we | k_fl, 8'h01, 8'h00);
        ex({2'h0, 4'hF, 1'b1, 7'h22}, k_we, 8'h01, st, 8'h01);
        br({2'h0, 4'hB, 1'b0, 7'h22}, k_fl, 8'h00, 8'h00);
        ex({2'h1, 2'h1, 3'd7, 7'h22}, k_we, 8'h00, st, 8'h81);
        ex({2'h1, 2'h0, 3'd0, 7'h22}, k_we, 8'h00, st, 8'h80);
        br({2'h1, 2'h2, 3'd0, 7'h22}, k_fl, 8'h00, 8'h00);
        ex({2'h1, 2'h3, 3'd0, 7'h22}, 8'h00, 8'h00, st, 8'h00);
        br({2'h1, 2'h3, 3'd7, 7'h22}, k_fl, 8'h00, 8'h00);
        ex({2'h1, 2'h2, 3'd7, 7'h22}, 8'h00, 8'h00, st, 8'h00);
    endtask

    task automatic t_branch;
        br({2'h2, 1'b0, 11'h5A5}, k_pu | k_pc | k_fl, 8'h00, 8'h00);
        br({2'h2, 1'b1, 11'h123}, k_pc | k_fl, 8'h00, 8'h00);
        br(14'h0008, k_po | k_fl, 8'h00, 8'h00);
        br(14'h0009, k_po | k_fl, 8'h00, 8'h00);
        br({2'h3, 4'h4, 8'h3C}, k_po | k_fl, 8'h3C, 8'h00);
    endtask

    task automatic t_special;
        ex(14'h0063, k_sb | k_wd, 8'h3C, 5'h10, 8'h00);
        ex(14'h0064, k_wd, 8'h3C, 5'h18, 8'h00);
        prescaler_to_timer <= 1'b1;
        ex({2'h0, 4'h0, 1'b1, 7'h01}, k_we | k_pr, 8'h3C, 5'h18, 8'h3C);
        prescaler_to_timer <= 1'b0;
        ex({2'h0, 4'h0, 1'b1, 7'h01}, k_we, 8'h3C, 5'h18, 8'h3C);
        ex({2'h0, 4'h0, 1'b1, 7'h05}, k_we, 8'h3C, 5'h18, 8'h3C);
        ex({2'h0, 4'h8, 1'b1, 7'h05}, k_we, 8'h3C, 5'h18, 8'hC3);
        ex(14'h0060, 8'h00, 8'h3C, 5'h18, 8'h00);
    endtask

    // Reset, align to the first cycle end, then run
    initial begin
        st = 5'h18;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        do @(posedge clock); while (fetch_q !== 1'b1);
        t_literal();
        t_byte();
        t_skip();
        t_branch();
        t_special();
        close_out();
    end
endmodule

`default_nettype wire
